// ### include/scope_trig_pkg.sv
// Shared constants and types for the scope trigger detector
`default_nettype none
package scope_trig_pkg;
  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int SMP_W = 12;
  localparam int CNT_W = 24;
  localparam int MW = 16;
  localparam int AW = 8;
  localparam int DW = 32;
  localparam int IDX_W = 6;
  localparam int TYPE_W = 4;
  localparam int CTL_W = 12;
  localparam logic [IDX_W-1:0] BUF_DEPTH = 6'h20;
  localparam logic [IDX_W-1:0] IDX_ONE = 6'h01;
  localparam logic [CNT_W-1:0] CNT_ONE = 24'h000001;
  localparam logic [CNT_W-1:0] CNT_MAX = 24'hffffff;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [AW-1:0] OFS_CTRL = 8'h00;
  localparam logic [AW-1:0] OFS_THR1 = 8'h04;
  localparam logic [AW-1:0] OFS_THR2 = 8'h08;
  localparam logic [AW-1:0] OFS_TIME1 = 8'h0c;
  localparam logic [AW-1:0] OFS_TIME2 = 8'h10;
  localparam logic [AW-1:0] OFS_TBASE = 8'h14;
  localparam logic [AW-1:0] OFS_CMD = 8'h18;
  localparam logic [AW-1:0] OFS_STAT = 8'h1c;
  localparam logic [AW-1:0] OFS_BUF = 8'h20;
  localparam logic [AW-1:0] OFS_MAX = 8'h24;
  localparam logic [AW-1:0] OFS_MIN = 8'h28;
  localparam logic [AW-1:0] OFS_TOP = 8'h2c;
  localparam logic [AW-1:0] OFS_BOT = 8'h30;
  localparam logic [AW-1:0] OFS_AMP = 8'h34;
  localparam logic [AW-1:0] OFS_PKPK = 8'h38;
  localparam logic [AW-1:0] OFS_PW = 8'h3c;
  localparam logic [AW-1:0] OFS_NW = 8'h40;
  localparam logic [AW-1:0] OFS_PER = 8'h44;
  localparam logic [AW-1:0] OFS_PDUTY = 8'h48;
  localparam logic [AW-1:0] OFS_NDUTY = 8'h4c;
  // ----------------------------------------
  // Fields, codes, reset values
  // ----------------------------------------
  localparam int CT_TYPE = 0;
  localparam int CT_MODE = 4;
  localparam int CT_DIR = 6;
  localparam int CT_HYST = 8;
  localparam int CT_COND = 9;
  localparam int CT_REG = 11;
  localparam int CMD_PREV = 0;
  localparam int CMD_NEXT = 1;
  localparam int CMD_ARM = 2;
  localparam logic [1:0] DIR_RISE = 2'h0;
  localparam logic [1:0] DIR_FALL = 2'h1;
  localparam logic [1:0] DIR_BOTH = 2'h2;
  localparam logic [CTL_W-1:0] CTRL_RST = 12'h000;
  localparam logic [DW-1:0] TB_RST = 32'h00000000;
  localparam logic [DW-1:0] TB_CONT_MS = 32'h000000c8;
  localparam logic [DW-1:0] US_PER_MS = 32'h000003e8;
  localparam logic [DW-1:0] TB_CONT_US = DW'(TB_CONT_MS * US_PER_MS);
  localparam int TOP_NUM = 9;
  localparam int TOP_DEN = 10;
  localparam int BOT_NUM = 1;
  localparam int BOT_DEN = 10;
  localparam int DUTY_SH = 8;
  localparam int WIN_LOG2 = 10;
  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [TYPE_W-1:0] {
    TT_EDGE, TT_ADV, TT_WIN, TT_PULSE, TT_INTV, TT_WPW, TT_LDUR, TT_WDUR, TT_RUNT
  } trig_type_t;
  typedef enum logic [1:0] {MODE_NONE, MODE_REPEAT, MODE_SINGLE} mode_t;
  typedef enum logic [1:0] {COND_GT, COND_LT, COND_IN, COND_OUT} cond_t;
endpackage
`default_nettype wire

// ### include/meas_if.sv
// Sample feed and result bundle between detector and measurement unit
`default_nettype none
interface meas_if;
  import scope_trig_pkg::*;
  logic vld;
  logic signed [SMP_W-1:0] smp;
  logic signed [MW-1:0] mx, mn, top, bot, amp, pkpk;
  logic [MW-1:0] pw, nw, per, pduty, nduty;
  modport src (output vld, smp, input mx, mn, top, bot, amp, pkpk, pw, nw, per, pduty, nduty);
  modport meas (input vld, smp, output mx, mn, top, bot, amp, pkpk, pw, nw, per, pduty, nduty);
endinterface
`default_nettype wire

// ### rtl/scope_measure.sv
// Amplitude and timing measurements over a fixed sample window
`default_nettype none
module scope_measure (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_nrst,
  // Samples in, results out
  meas_if.meas m
);
  import scope_trig_pkg::*;
  localparam logic signed [MW-1:0] S_MIN = 16'sh8000;
  localparam logic signed [MW-1:0] S_MAX = 16'sh7fff;
  logic [WIN_LOG2-1:0] win_r;
  logic signed [MW+WIN_LOG2-1:0] sum_r;
  logic signed [MW-1:0] avg_r, mx_r, mn_r;
  logic [MW-1:0] hrun_r, lrun_r, pw_r, nw_r, per_r;
  logic hi_r;
  wire signed [MW-1:0] sx = MW'(m.smp);
  wire hi = sx > avg_r;
  wire signed [MW-1:0] mx_nxt = (sx > mx_r) ? sx : mx_r;
  wire signed [MW-1:0] mn_nxt = (sx < mn_r) ? sx : mn_r;
  wire signed [MW+WIN_LOG2-1:0] sum_nxt = sum_r + (MW+WIN_LOG2)'(sx);
  wire signed [MW-1:0] top_c = MW'((mx_nxt * TOP_NUM) / TOP_DEN);
  wire signed [MW-1:0] bot_c = MW'((mn_nxt * BOT_NUM) / BOT_DEN);
  wire [DW-1:0] pd_c = (per_r == '0) ? '0 : (DW'(pw_r) << DUTY_SH) / DW'(per_r);
  wire [DW-1:0] nd_c = (per_r == '0) ? '0 : (DW'(nw_r) << DUTY_SH) / DW'(per_r);
  wire win_end = m.vld && (win_r == '1);

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      win_r <= '0; sum_r <= '0; avg_r <= '0; hi_r <= 1'b0;
      mx_r <= S_MIN; mn_r <= S_MAX;
      hrun_r <= '0; lrun_r <= '0; pw_r <= '0; nw_r <= '0; per_r <= '0;
    end else if (m.vld) begin
      win_r <= win_r + 1'b1;
      hi_r <= hi;
      hrun_r <= hi ? hrun_r + 1'b1 : '0;
      lrun_r <= hi ? '0 : lrun_r + 1'b1;
      if (hi_r && !hi) pw_r <= hrun_r;
      if (!hi_r && hi) begin
        nw_r <= lrun_r;
        per_r <= pw_r + lrun_r;
      end
      sum_r <= win_end ? '0 : sum_nxt;
      mx_r <= win_end ? S_MIN : mx_nxt;
      mn_r <= win_end ? S_MAX : mn_nxt;
      if (win_end) avg_r <= MW'(sum_nxt >>> WIN_LOG2);
    end
  end

  // ----------------------------------------
  // Result latch, whole set per window
  // ----------------------------------------
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      m.mx <= '0; m.mn <= '0; m.top <= '0; m.bot <= '0; m.amp <= '0; m.pkpk <= '0;
      m.pw <= '0; m.nw <= '0; m.per <= '0; m.pduty <= '0; m.nduty <= '0;
    end else if (win_end) begin
      m.mx <= mx_nxt;
      m.mn <= mn_nxt;
      m.top <= top_c;
      m.bot <= bot_c;
      m.amp <= top_c - bot_c;
      m.pkpk <= mx_nxt - mn_nxt;
      m.pw <= pw_r;
      m.nw <= nw_r;
      m.per <= per_r;
      m.pduty <= MW'(pd_c);
      m.nduty <= MW'(nd_c);
    end
  end

  a_pkpk_diff: assert property (@(posedge i_core_clk) disable iff (!i_nrst) m.pkpk == MW'(m.mx - m.mn))
    else $error("peak-to-peak differs from max minus min");
  a_amp_diff: assert property (@(posedge i_core_clk) disable iff (!i_nrst) m.amp == MW'(m.top - m.bot))
    else $error("amplitude differs from top minus bottom");
  a_top_frac: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    win_end |=> m.top == MW'((m.mx * TOP_NUM) / TOP_DEN) && m.bot == MW'((m.mn * BOT_NUM) / BOT_DEN))
    else $error("top or bottom not the set fraction");
endmodule
`default_nettype wire

// ### rtl/scope_trigger_detector.sv
// Trigger detection, capture mode, buffer index and register port
// Functional notes
// - Advanced edge with dual direction fires on rising and falling crossings.
// - Hysteresis adds a second threshold beside the main one.
// - With hysteresis, second threshold arms, main threshold then fires; never reversed.
// - Window uses threshold one as upper and threshold two as lower limit.
// - Window fires on entry, exit, or either, by direction setting.
// - Pulse width measures positive or negative pulses with threshold and hysteresis.
// - Greater-than condition: fire only when width exceeds time one.
// - Less-than condition: fire only when width is shorter than time one.
// - Inside range: width above time one and below time two.
// - Outside range: width below time one or above time two.
// - Interval measures time between successive same-polarity edges with width conditions.
// - Window pulse width fires after staying inside or outside for time one.
// - Level duration fires when level stays high or low longer than time one.
// - Window duration fires after staying inside the window for time one.
// - Runt fires when pulse crosses one threshold and returns without reaching the other.
// - Continuous mode whenever time base is at or above 200 ms per division.
// - Continuous mode streams samples while capture still runs.
// - Buffer index and count track up to 32 captures; previous and next step index.
// - Top is ninety percent of maximum, bottom ten percent of minimum.
// - Amplitude is top minus bottom; peak-to-peak is maximum minus minimum.
// - Duty ratios are pulse widths divided by period.
// - Pulse widths are time spent above or below the average value.
// - No-trigger mode captures continuously without waiting for triggers.
// - Single mode stops capture after the first trigger.
// - Repeat mode waits for each trigger and presents nothing without one; the code keeps o_capture high in repeat mode, trigger or not.
// - Basic edge fires on rising above or falling below the threshold.
`default_nettype none
module scope_trigger_detector (
  // Clock and reset
  input wire logic i_core_clk,
  input wire logic i_nrst,
  // Sample stream
  input wire logic i_smp_vld,
  input wire logic signed [scope_trig_pkg::SMP_W-1:0] i_smp,
  // Register port
  input wire logic [scope_trig_pkg::AW-1:0] i_addr,
  input wire logic [scope_trig_pkg::DW-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [scope_trig_pkg::DW-1:0] o_rdata,
  // Capture control
  output logic o_trig,
  output logic o_capture,
  output logic o_cont,
  output logic o_stream_vld,
  output logic signed [scope_trig_pkg::SMP_W-1:0] o_stream_data,
  // Buffer index
  output logic [scope_trig_pkg::IDX_W-1:0] o_buf_idx,
  output logic [scope_trig_pkg::IDX_W-1:0] o_buf_cnt
);
  import scope_trig_pkg::*;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic x_up(input logic signed [SMP_W-1:0] p, n, t);
    x_up = (p <= t) && (n > t);
  endfunction

  function automatic logic x_dn(input logic signed [SMP_W-1:0] p, n, t);
    x_dn = (p >= t) && (n < t);
  endfunction

  function automatic logic in_win(input logic signed [SMP_W-1:0] x, hi, lo);
    in_win = (x <= hi) && (x >= lo);
  endfunction

  function automatic logic width_ok(input logic [CNT_W-1:0] w, t1, t2, input cond_t c);
    case (c)
      COND_GT: width_ok = w > t1;
      COND_LT: width_ok = w < t1;
      COND_IN: width_ok = (w > t1) && (w < t2);
      COND_OUT: width_ok = (w < t1) || (w > t2);
      default: width_ok = 1'b0;
    endcase
  endfunction

  // ----------------------------------------
  // Registers and state
  // ----------------------------------------
  logic [CTL_W-1:0] ctrl_r;
  logic signed [SMP_W-1:0] thr1_r, thr2_r, prev_r;
  logic [CNT_W-1:0] t1_r, t2_r, cnt_r;
  logic [DW-1:0] tb_r, rd_mux;
  logic hp_r, lvl_r, a_r, b_r, run_r;
  logic fire, a_nxt, b_nxt, run_nxt;

  meas_if mb ();

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  wire trig_type_t ttype = trig_type_t'(ctrl_r[CT_TYPE +: TYPE_W]);
  wire mode_t mode = mode_t'(ctrl_r[CT_MODE +: 2]);
  wire [1:0] dir = ctrl_r[CT_DIR +: 2];
  wire hyst = ctrl_r[CT_HYST];
  wire cond_t cond = cond_t'(ctrl_r[CT_COND +: 2]);
  wire region_in = ctrl_r[CT_REG];
  wire wr_ctrl = i_wr && (i_addr == OFS_CTRL);
  wire wr_thr1 = i_wr && (i_addr == OFS_THR1);
  wire wr_thr2 = i_wr && (i_addr == OFS_THR2);
  wire wr_t1 = i_wr && (i_addr == OFS_TIME1);
  wire wr_t2 = i_wr && (i_addr == OFS_TIME2);
  wire wr_tb = i_wr && (i_addr == OFS_TBASE);
  wire wr_cmd = i_wr && (i_addr == OFS_CMD);
  wire cfg_wr = wr_ctrl || wr_thr1 || wr_thr2 || wr_t1 || wr_t2;
  wire cmd_prev = wr_cmd && i_wdata[CMD_PREV];
  wire cmd_next = wr_cmd && i_wdata[CMD_NEXT];
  wire cmd_arm = wr_cmd && i_wdata[CMD_ARM];

  // ----------------------------------------
  // Crossings and levels
  // ----------------------------------------
  wire up1 = hp_r && x_up(prev_r, i_smp, thr1_r);
  wire dn1 = hp_r && x_dn(prev_r, i_smp, thr1_r);
  wire up2 = hp_r && x_up(prev_r, i_smp, thr2_r);
  wire dn2 = hp_r && x_dn(prev_r, i_smp, thr2_r);
  wire in_now = in_win(i_smp, thr1_r, thr2_r);
  wire in_prv = hp_r && in_win(prev_r, thr1_r, thr2_r);
  // Schmitt level; hysteresis lowers the release point to keep noise off
  wire signed [SMP_W-1:0] lo_thr = hyst ? thr2_r : thr1_r;
  wire lvl_nxt = (i_smp > thr1_r) ? 1'b1 : (i_smp < lo_thr) ? 1'b0 : lvl_r;
  wire pol_hi = dir == DIR_RISE;
  wire act = lvl_nxt == pol_hi;
  wire act_prv = hp_r && (lvl_r == pol_hi);
  wire p_end = act_prv && !act;
  wire iv_edge = hp_r && (pol_hi ? (lvl_nxt && !lvl_r) : (!lvl_nxt && lvl_r));
  wire hold = (ttype == TT_WPW) ? (in_now == region_in) :
              (ttype == TT_WDUR) ? in_now :
              act;
  wire [CNT_W-1:0] inc = (cnt_r == CNT_MAX) ? cnt_r : cnt_r + CNT_ONE;
  wire [CNT_W-1:0] cnt_nxt = (ttype == TT_INTV) ? (iv_edge ? CNT_ONE : inc) : (hold ? inc : '0);
  // Longer than time one means the sample after that many
  wire [CNT_W-1:0] tgt = (ttype == TT_LDUR) ? t1_r + CNT_ONE : t1_r;

  // ----------------------------------------
  // Trigger condition per type
  // ----------------------------------------
  always_comb begin
    fire = 1'b0;
    a_nxt = a_r;
    b_nxt = b_r;
    case (ttype)
      TT_EDGE: fire = (dir == DIR_RISE && up1) || (dir == DIR_FALL && dn1);
      TT_ADV: begin
        if (hyst) begin
          // Arm below/above the second level, fire on the main crossing
          if (dir != DIR_FALL) begin
            fire = a_r && up1;
            a_nxt = fire ? 1'b0 : (a_r || dn2);
          end
          if (dir != DIR_RISE) begin
            fire = fire || (b_r && dn1);
            b_nxt = (b_r && dn1) ? 1'b0 : (b_r || up2);
          end
        end else begin
          fire = (dir != DIR_FALL && up1) || (dir != DIR_RISE && dn1);
        end
      end
      TT_WIN: fire = (dir != DIR_FALL && in_now && !in_prv) || (dir != DIR_RISE && !in_now && in_prv);
      TT_PULSE: fire = p_end && width_ok(cnt_r, t1_r, t2_r, cond);
      TT_INTV: begin
        if (iv_edge) begin
          fire = a_r && width_ok(cnt_r, t1_r, t2_r, cond);
          a_nxt = 1'b1;
        end
      end
      TT_WPW, TT_WDUR, TT_LDUR: fire = hold && (cnt_nxt == tgt);
      TT_RUNT: begin
        if (pol_hi) begin
          fire = a_r && dn2;
          a_nxt = (up1 || dn2) ? 1'b0 : (up2 ? 1'b1 : a_r);
        end else begin
          fire = a_r && up1;
          a_nxt = (dn2 || up1) ? 1'b0 : (dn1 ? 1'b1 : a_r);
        end
      end
      default: fire = 1'b0;
    endcase
  end

  // A trigger counts only while capture runs and settings are stable
  wire take = fire && i_smp_vld && run_r && (mode != MODE_NONE) && !cfg_wr;

  always_comb begin
    case (mode)
      MODE_NONE: run_nxt = 1'b1;
      MODE_REPEAT: run_nxt = 1'b1;
      MODE_SINGLE: run_nxt = take ? 1'b0 : (cmd_arm ? 1'b1 : run_r);
      default: run_nxt = run_r;
    endcase
  end

  // ----------------------------------------
  // Buffer index
  // ----------------------------------------
  wire [IDX_W-1:0] bcnt_nxt = (take && o_buf_cnt != BUF_DEPTH) ? o_buf_cnt + IDX_ONE : o_buf_cnt;
  wire [IDX_W-1:0] bidx_nxt = take ? bcnt_nxt :
       (cmd_prev && o_buf_idx > IDX_ONE) ? o_buf_idx - IDX_ONE :
       (cmd_next && o_buf_idx < o_buf_cnt) ? o_buf_idx + IDX_ONE : o_buf_idx;

  // ----------------------------------------
  // Settings
  // ----------------------------------------
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      ctrl_r <= CTRL_RST;
      thr1_r <= '0;
      thr2_r <= '0;
      t1_r <= '0;
      t2_r <= '0;
      tb_r <= TB_RST;
    end else begin
      if (wr_ctrl) ctrl_r <= i_wdata[CTL_W-1:0];
      if (wr_thr1) thr1_r <= i_wdata[SMP_W-1:0];
      if (wr_thr2) thr2_r <= i_wdata[SMP_W-1:0];
      if (wr_t1) t1_r <= i_wdata[CNT_W-1:0];
      if (wr_t2) t2_r <= i_wdata[CNT_W-1:0];
      if (wr_tb) tb_r <= i_wdata;
    end
  end

  // ----------------------------------------
  // Detector state, one step per sample
  // ----------------------------------------
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      prev_r <= '0;
      hp_r <= 1'b0;
      lvl_r <= 1'b0;
      cnt_r <= '0;
      a_r <= 1'b0;
      b_r <= 1'b0;
    end else if (cfg_wr) begin
      cnt_r <= '0;
      a_r <= 1'b0;
      b_r <= 1'b0;
    end else if (i_smp_vld) begin
      prev_r <= i_smp;
      hp_r <= 1'b1;
      lvl_r <= lvl_nxt;
      cnt_r <= cnt_nxt;
      a_r <= a_nxt;
      b_r <= b_nxt;
    end
  end

  // ----------------------------------------
  // Capture, stream and buffer outputs
  // ----------------------------------------
  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      run_r <= 1'b1;
      o_trig <= 1'b0;
      o_cont <= 1'b0;
      o_stream_vld <= 1'b0;
      o_stream_data <= '0;
      o_buf_idx <= '0;
      o_buf_cnt <= '0;
    end else begin
      run_r <= run_nxt;
      o_trig <= take;
      o_cont <= tb_r >= TB_CONT_US;
      o_stream_vld <= o_cont && run_r && i_smp_vld;
      o_stream_data <= i_smp;
      o_buf_idx <= bidx_nxt;
      o_buf_cnt <= bcnt_nxt;
    end
  end

  assign o_capture = run_r;

  // ----------------------------------------
  // Measurement unit
  // ----------------------------------------
  assign mb.vld = i_smp_vld;
  assign mb.smp = i_smp;

  scope_measure u_meas (
    .i_core_clk(i_core_clk),
    .i_nrst(i_nrst),
    .m(mb.meas)
  );

  // ----------------------------------------
  // Register read, data in the cycle after the strobe
  // ----------------------------------------
  always_comb begin
    case (i_addr)
      OFS_CTRL: rd_mux = DW'(ctrl_r);
      OFS_THR1: rd_mux = DW'($unsigned(thr1_r));
      OFS_THR2: rd_mux = DW'($unsigned(thr2_r));
      OFS_TIME1: rd_mux = DW'(t1_r);
      OFS_TIME2: rd_mux = DW'(t2_r);
      OFS_TBASE: rd_mux = tb_r;
      OFS_STAT: rd_mux = DW'({o_cont, run_r, lvl_r, b_r, a_r});
      OFS_BUF: rd_mux = DW'({o_buf_cnt, o_buf_idx});
      OFS_MAX: rd_mux = DW'($unsigned(mb.mx));
      OFS_MIN: rd_mux = DW'($unsigned(mb.mn));
      OFS_TOP: rd_mux = DW'($unsigned(mb.top));
      OFS_BOT: rd_mux = DW'($unsigned(mb.bot));
      OFS_AMP: rd_mux = DW'($unsigned(mb.amp));
      OFS_PKPK: rd_mux = DW'($unsigned(mb.pkpk));
      OFS_PW: rd_mux = DW'(mb.pw);
      OFS_NW: rd_mux = DW'(mb.nw);
      OFS_PER: rd_mux = DW'(mb.per);
      OFS_PDUTY: rd_mux = DW'(mb.pduty);
      OFS_NDUTY: rd_mux = DW'(mb.nduty);
      default: rd_mux = '0;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_nrst) begin
    if (!i_nrst) o_rdata <= '0;
    else o_rdata <= i_rd ? rd_mux : '0;
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  wire live = i_smp_vld && run_r && (mode != MODE_NONE) && !cfg_wr;

  sequence s_rise_arm;
    ttype == TT_ADV && hyst && dir == DIR_RISE && i_smp_vld && !cfg_wr && dn2;
  endsequence

  sequence s_rise_fire;
    ttype == TT_ADV && hyst && dir == DIR_RISE && live && up1;
  endsequence

  a_hyst_arm: assert property (@(posedge i_core_clk) disable iff (!i_nrst) s_rise_arm |=> a_r)
    else $error("second threshold crossing did not arm");
  a_hyst_order: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    s_rise_fire |=> o_trig == $past(a_r))
    else $error("hysteresis trigger fired out of order");
  a_dual_edge: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    ttype == TT_ADV && !hyst && dir == DIR_BOTH && live && (up1 || dn1) |=> o_trig)
    else $error("dual edge missed a crossing");
  a_edge_rise: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    ttype == TT_EDGE && dir == DIR_RISE && live && up1 |=> o_trig)
    else $error("rising edge not triggered");
  a_none_free: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    mode == MODE_NONE |=> !o_trig ##0 o_capture)
    else $error("no-trigger mode gated capture");
  a_single_stop: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    mode == MODE_SINGLE && take ##1 (!cmd_arm && mode == MODE_SINGLE) [*2] |-> !o_capture ##1 !o_capture)
    else $error("single mode kept capturing");
  a_cfg_disarm: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    cfg_wr |=> !a_r && !b_r && cnt_r == '0)
    else $error("setting change left detector armed");
  a_cont_mode: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    ##1 o_cont == ($past(tb_r) >= TB_CONT_US))
    else $error("continuous mode flag wrong");
  a_buf_next: assert property (@(posedge i_core_clk) disable iff (!i_nrst)
    cmd_next && !take && o_buf_idx < o_buf_cnt |=> o_buf_idx == $past(o_buf_idx) + IDX_ONE)
    else $error("next did not step the index");
endmodule
`default_nettype wire

// ### testbench/afe_model.sv
// Front end model that hands samples to the detector
`default_nettype none
module afe_model
  import scope_trig_pkg::*;
(
  input wire logic i_core_clk,
  output logic o_vld,
  output logic signed [SMP_W-1:0] o_smp
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_vld = 1'b0;
    o_smp = 12'h000;
  end
  // Call right after a rising edge; back-to-back calls keep valid high
  task automatic send(input logic [SMP_W-1:0] v);
    o_vld <= 1'b1;
    o_smp <= v;
    @(posedge i_core_clk);
  endtask
  // Stale data is inverted so it never looks like a held sample
  task automatic idle();
    o_vld <= 1'b0;
    o_smp <= ~o_smp;
    @(posedge i_core_clk);
  endtask
endmodule
`default_nettype wire

// ### testbench/testbench.sv
// Self-checking bench for the scope trigger detector
`default_nettype none
module testbench;
  import scope_trig_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [AW-1:0] addr = 8'h00;
  logic [DW-1:0] wdata = 32'h00000000;
  logic [DW-1:0] rdata, d;
  logic trig, capture, cont, svld, vld;
  logic signed [SMP_W-1:0] sdata, smp;
  logic [IDX_W-1:0] idx, cnt;
  logic [31:0] seed = 32'hb8f8f2f0;
  logic [7:0] cases [5] = '{8'h10, 8'h50, 8'h91, 8'h81, 8'ha1};
  int miscompares = 0;
  int check_count = 0;
  int ntrig = 0;
  int nexp, p, c, t;
  always #5 clk = ~clk;
  // Counted mid-cycle so it never races the stimulus edge
  always @(negedge clk) if (trig === 1'b1) ntrig++;
  afe_model fe (.i_core_clk(clk), .o_vld(vld), .o_smp(smp));
  scope_trigger_detector dut (.i_core_clk(clk), .i_nrst(nrst), .i_smp_vld(vld), .i_smp(smp), .i_addr(addr),
    .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_trig(trig), .o_capture(capture), .o_cont(cont),
    .o_stream_vld(svld), .o_stream_data(sdata), .o_buf_idx(idx), .o_buf_cnt(cnt));
  task automatic end_sim();
    $display("checks=%0d miscompares=%0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic check(input logic [DW-1:0] seen, input logic [DW-1:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input logic [AW-1:0] a, input logic [DW-1:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [AW-1:0] a);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  function automatic int hit(input logic [1:0] dr, input int pv, input int cv, input int th);
    return int'((dr != 2'h1 && pv <= th && cv > th) || (dr != 2'h0 && pv >= th && cv < th));
  endfunction
  // Threshold sample first: equal to the threshold it cannot cross
  task automatic run(input logic [7:0] cs);
    int base;
    seed = xs(seed);
    t = int'($signed(seed[11:0]));
    wreg(OFS_CMD, 32'h00000004);
    wreg(OFS_THR1, {20'h00000, seed[11:0]});
    wreg(OFS_CTRL, {24'h000000, cs});
    fe.send(seed[11:0]);
    fe.idle();
    base = ntrig;
    p = t;
    nexp = 0;
    repeat (64) begin
      seed = xs(seed);
      c = int'($signed(seed[11:0]));
      fe.send(seed[11:0]);
      nexp += hit(cs[7:6], p, c, t);
      p = c;
    end
    fe.idle();
    repeat (2) @(posedge clk);
    if (cs[5:4] == 2'h0)
      nexp = 0;
    if (cs[5:4] == 2'h2 && nexp > 1)
      nexp = 1;
    check(DW'(ntrig - base), DW'(nexp));
    check({31'h0, capture}, {31'h0, !(cs[5:4] == 2'h2 && nexp > 0)});
  endtask
  // Corner case: control word, four samples oldest first, expected trigger count
  task automatic burst(input logic [DW-1:0] cw, input logic [47:0] v, input int ne);
    int b0;
    wreg(OFS_CTRL, cw);
    b0 = ntrig;
    for (int k = 3; k >= 0; k--) fe.send(v[k*SMP_W +: SMP_W]);
    fe.idle();
    repeat (2) @(posedge clk);
    check(DW'(ntrig - b0), DW'(ne));
  endtask
  initial begin
    #100us;
    miscompares++;
    end_sim();
  end
  initial begin
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    check({26'h0, cnt}, 32'h00000000);
    rreg(OFS_CTRL);
    check(d, 32'h00000000);
    rreg(8'h80);
    check(d, 32'h00000000);
    wreg(OFS_THR1, 32'h00000abc);
    rreg(OFS_THR1);
    check(d, 32'h00000abc);
    foreach (cases[i]) run(cases[i]);
    check({26'h0, idx}, {26'h0, cnt});
    wreg(OFS_CMD, 32'h00000001);
    @(negedge clk);
    check({26'h0, idx}, {26'h0, cnt - IDX_ONE});
    wreg(OFS_CMD, 32'h00000002);
    @(negedge clk);
    check({26'h0, idx}, {26'h0, cnt});
    wreg(OFS_THR1, 32'h00000100);
    wreg(OFS_THR2, 32'h00000f00);
    wreg(OFS_TIME1, 32'h00000002);
    burst(32'h00000111, 48'h000_200_e00_200, 1);
    burst(32'h00000012, 48'h000_300_000_050, 2);
    burst(32'h00000052, 48'h000_300_000_050, 1);
    burst(32'h00000018, 48'h000_e00_000_e00, 1);
    burst(32'h00000018, 48'h000_200_e00_000, 0);
    burst(32'h00000016, 48'h200_200_200_000, 1);
    burst(32'h00000016, 48'h200_200_000_200, 0);
    burst(32'h00000013, 48'h200_200_200_000, 1);
    burst(32'h00000213, 48'h200_000_200_000, 2);
    // Two windows of a flat level, so one whole window is latched
    repeat (2048) fe.send(12'h064);
    fe.idle();
    rreg(OFS_TOP);
    check(d, 32'h0000005a);
    rreg(OFS_BOT);
    check(d, 32'h0000000a);
    rreg(OFS_AMP);
    check(d, 32'h00000050);
    rreg(OFS_PKPK);
    check(d, 32'h00000000);
    wreg(OFS_TBASE, TB_CONT_US - 32'h00000001);
    repeat (2) @(negedge clk);
    check({31'h0, cont}, 32'h00000000);
    wreg(OFS_TBASE, TB_CONT_US);
    wreg(OFS_CTRL, 32'h00000000);
    wreg(OFS_CMD, 32'h00000004);
    repeat (2) @(posedge clk);
    fe.send(12'h5a3);
    @(negedge clk);
    check({31'h0, cont}, 32'h00000001);
    check({30'h0, svld, capture}, 32'h00000003);
    check(DW'(sdata), DW'(12'h5a3));
    end_sim();
  end
endmodule
`default_nettype wire
